/* File: hw/card_socket_signals.sv */
/*
  two-socket card signal logic: apb register slave, card cycle sequencer per socket,
  card enables, attribute select, read and write strobes, reset, power and sense.
  assumes pins are synchronous to nothing; the pad ring resolves the data bus from
  the output enable; pready is always high so every apb access takes two cycles.
*/
`default_nettype none
module card_socket_signals
  import card_socket_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [CARD_ADDR_W-1:0] socket_a_card_address,
  input wire logic [CARD_DATA_W-1:0] socket_a_card_data_in,
  output logic [CARD_DATA_W-1:0] socket_a_card_data_out,
  output logic socket_a_card_data_oe,
  output logic socket_a_card_enable1_n,
  output logic socket_a_card_enable2_n,
  output logic socket_a_attr_select_n,
  output logic socket_a_output_enable_n,
  output logic socket_a_write_enable_n,
  output logic socket_a_io_read_n,
  output logic socket_a_io_write_n,
  output logic socket_a_card_reset,
  output logic socket_a_power_ctl_0,
  output logic socket_a_power_ctl_1,
  input wire logic socket_a_volt_sense_0,
  input wire logic socket_a_volt_sense_1,
  input wire logic socket_a_wait_n,
  input wire logic socket_a_io16_n,
  output logic [CARD_ADDR_W-1:0] socket_b_card_address,
  input wire logic [CARD_DATA_W-1:0] socket_b_card_data_in,
  output logic [CARD_DATA_W-1:0] socket_b_card_data_out,
  output logic socket_b_card_data_oe,
  output logic socket_b_card_enable1_n,
  output logic socket_b_card_enable2_n,
  output logic socket_b_attr_select_n,
  output logic socket_b_output_enable_n,
  output logic socket_b_write_enable_n,
  output logic socket_b_io_read_n,
  output logic socket_b_io_write_n,
  output logic socket_b_card_reset,
  output logic socket_b_power_ctl_0,
  output logic socket_b_power_ctl_1,
  input wire logic socket_b_volt_sense_0,
  input wire logic socket_b_volt_sense_1,
  input wire logic socket_b_wait_n,
  input wire logic socket_b_io16_n
);
  // synchronised pin group per socket: {vs1, vs0, wait_n, io16_n, data}
  localparam int IN_W = CARD_DATA_W + 4;
  localparam int IN_WAIT = CARD_DATA_W + 1;
  localparam int IN_IO16 = CARD_DATA_W;
  localparam int IN_VS0 = CARD_DATA_W + 2;
  localparam int IN_VS1 = CARD_DATA_W + 3;

  if (ADDR_W < SOCK_BIT + 1) begin : g_addr_chk
    $error("ADDR_W too small for two socket windows");
  end
  if (STROBE_CYC > 15 || SETUP_CYC > 15 || HOLD_CYC > 15) begin : g_cnt_chk
    $error("cycle timing exceeds the phase counter");
  end

  // card enable pair {ce2_n, ce1_n}: word, odd byte on high lane, or byte on low lane
  function automatic logic [1:0] ce_decode(input logic wide, input logic a0);
    logic [1:0] ce;
    ce = 2'h2;
    if (wide && !a0) begin
      ce = 2'h0;
    end else if (wide) begin
      ce = 2'h1;
    end
    return ce;
  endfunction

  logic [IN_W-1:0] pin_in [2];
  logic [IN_W-1:0] sync1_reg [2];
  logic [IN_W-1:0] sync2_reg [2];
  logic [IN_W-1:0] sync3_reg [2];
  logic [IN_W-1:0] filt_reg [2];
  logic [CTRL_W-1:0] ctrl_reg [2];
  logic [CARD_ADDR_W-1:0] addr_reg [2];
  logic [CARD_DATA_W-1:0] wdata_reg [2];
  logic [CARD_DATA_W-1:0] rdata_reg [2];
  logic [CMD_W-1:0] cmd_reg [2];
  logic [CNT_W-1:0] cnt_reg [2];
  logic err_reg [2];
  cycle_state_e state_reg [2];
  logic [CARD_ADDR_W-1:0] card_addr_reg [2];
  logic [1:0] ce_reg [2];
  logic attr_n_reg [2];
  logic oe_n_reg [2];
  logic we_n_reg [2];
  logic ior_n_reg [2];
  logic iow_n_reg [2];
  logic data_oe_reg [2];
  logic [1:0] wr_sock;
  logic [4:0] off;
  logic sock;
  logic mapped;

  // inputs gathered per socket; the card input acknowledge has no pin here
  assign pin_in[0] = {socket_a_volt_sense_1, socket_a_volt_sense_0, socket_a_wait_n,
                      socket_a_io16_n, socket_a_card_data_in};
  assign pin_in[1] = {socket_b_volt_sense_1, socket_b_volt_sense_0, socket_b_wait_n,
                      socket_b_io16_n, socket_b_card_data_in};

  // apb decode: word offset inside a socket window, window chosen by SOCK_BIT
  assign off = {paddr[4:2], 2'h0};
  assign sock = paddr[SOCK_BIT];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:SOCK_BIT+1] == '0) &&
                  (off == OFF_CTRL || off == OFF_STATUS || off == OFF_ADDR ||
                   off == OFF_WDATA || off == OFF_CMD || off == OFF_RDATA);
  assign wr_sock[0] = psel && penable && pwrite && mapped && !sock;
  assign wr_sock[1] = psel && penable && pwrite && mapped && sock;
  assign pready = 1'b1;

  // read data and error are latched in the setup cycle so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !mapped;
      prdata <= 32'h0;
      if (mapped && !pwrite) begin
        unique case (off)
          OFF_CTRL: prdata <= 32'(ctrl_reg[sock]);
          OFF_STATUS: prdata <= 32'({err_reg[sock], state_reg[sock] != cyc_idle,
                                     filt_reg[sock][IN_VS1], filt_reg[sock][IN_VS0]});
          OFF_ADDR: prdata <= 32'(addr_reg[sock]);
          OFF_WDATA: prdata <= 32'(wdata_reg[sock]);
          OFF_CMD: prdata <= 32'(cmd_reg[sock]);
          default: prdata <= 32'(rdata_reg[sock]);
        endcase
      end
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_sock
    logic cmd_wr;
    logic start;
    logic io16_wide;
    assign cmd_wr = wr_sock[s] && off == OFF_CMD;
    // i/o commands need attribute select low, so common memory never sees i/o strobes
    assign start = cmd_wr && state_reg[s] == cyc_idle &&
                   (!pwdata[CMD_IO] || pwdata[CMD_ATTR]);
    // on i/o cycles the card's own 16-bit flag decides the width
    assign io16_wide = !filt_reg[s][IN_IO16];

    // three-stage synchroniser; a bit changes once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_reg[s] <= '1;
        sync2_reg[s] <= '1;
        sync3_reg[s] <= '1;
        filt_reg[s] <= '1;
      end else begin
        sync1_reg[s] <= pin_in[s];
        sync2_reg[s] <= sync1_reg[s];
        sync3_reg[s] <= sync2_reg[s];
        filt_reg[s] <= (sync2_reg[s] & sync3_reg[s]) |
                       (filt_reg[s] & (sync2_reg[s] | sync3_reg[s]));
      end
    end

    // software-visible setup registers
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_reg[s] <= CTRL_RST_VAL;
        addr_reg[s] <= '0;
        wdata_reg[s] <= '0;
      end else if (wr_sock[s]) begin
        if (off == OFF_CTRL) begin
          ctrl_reg[s] <= pwdata[CTRL_W-1:0];
        end
        if (off == OFF_ADDR) begin
          addr_reg[s] <= pwdata[CARD_ADDR_W-1:0];
        end
        if (off == OFF_WDATA) begin
          wdata_reg[s] <= pwdata[CARD_DATA_W-1:0];
        end
      end
    end

    // refused command flag: a new refusal beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        err_reg[s] <= 1'b0;
      end else if (cmd_wr && !start) begin
        err_reg[s] <= 1'b1;
      end else if (wr_sock[s] && off == OFF_STATUS && pwdata[ST_ERR]) begin
        err_reg[s] <= 1'b0;
      end
    end

    // card cycle sequencer: setup, strobe (stretched by wait), hold
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_reg[s] <= cyc_idle;
        cnt_reg[s] <= CNT_ZERO;
        cmd_reg[s] <= '0;
        rdata_reg[s] <= '0;
        card_addr_reg[s] <= '0;
        ce_reg[s] <= 2'h3;
        attr_n_reg[s] <= 1'b1;
        oe_n_reg[s] <= 1'b1;
        we_n_reg[s] <= 1'b1;
        ior_n_reg[s] <= 1'b1;
        iow_n_reg[s] <= 1'b1;
        data_oe_reg[s] <= 1'b0;
      end else begin
        unique case (state_reg[s])
          cyc_idle: begin
            if (start) begin
              cmd_reg[s] <= pwdata[CMD_W-1:0];
              state_reg[s] <= cyc_setup;
              cnt_reg[s] <= SETUP_LD;
              card_addr_reg[s] <= addr_reg[s];
              attr_n_reg[s] <= !pwdata[CMD_ATTR];
              ce_reg[s] <= ce_decode(ctrl_reg[s][CTRL_WIDE], addr_reg[s][0]);
              data_oe_reg[s] <= pwdata[CMD_WRITE];
            end
          end
          cyc_setup: begin
            cnt_reg[s] <= cnt_reg[s] - 4'h1;
            if (cnt_reg[s] == CNT_ZERO) begin
              state_reg[s] <= cyc_strobe;
              cnt_reg[s] <= STROBE_LD;
              if (cmd_reg[s][CMD_IO]) begin
                ce_reg[s] <= ce_decode(io16_wide, card_addr_reg[s][0]);
                iow_n_reg[s] <= !cmd_reg[s][CMD_WRITE];
                ior_n_reg[s] <= cmd_reg[s][CMD_WRITE];
              end else begin
                we_n_reg[s] <= !cmd_reg[s][CMD_WRITE];
                oe_n_reg[s] <= cmd_reg[s][CMD_WRITE];
              end
            end
          end
          cyc_strobe: begin
            if (cnt_reg[s] != CNT_ZERO) begin
              cnt_reg[s] <= cnt_reg[s] - 4'h1;
            end else if (filt_reg[s][IN_WAIT]) begin
              // wait seen high only after the minimum width
              state_reg[s] <= cyc_hold;
              cnt_reg[s] <= HOLD_LD;
              oe_n_reg[s] <= 1'b1;
              we_n_reg[s] <= 1'b1;
              ior_n_reg[s] <= 1'b1;
              iow_n_reg[s] <= 1'b1;
              if (!cmd_reg[s][CMD_WRITE]) begin
                rdata_reg[s] <= filt_reg[s][CARD_DATA_W-1:0];
              end
            end
          end
          cyc_hold: begin
            cnt_reg[s] <= cnt_reg[s] - 4'h1;
            if (cnt_reg[s] == CNT_ZERO) begin
              // address stays put; enables, attribute select and data drive drop
              state_reg[s] <= cyc_idle;
              ce_reg[s] <= 2'h3;
              data_oe_reg[s] <= 1'b0;
              attr_n_reg[s] <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // socket a pins
  assign socket_a_card_address = card_addr_reg[0];
  assign socket_a_card_data_out = wdata_reg[0];
  assign socket_a_card_data_oe = data_oe_reg[0];
  assign socket_a_card_enable1_n = ce_reg[0][0];
  assign socket_a_card_enable2_n = ce_reg[0][1];
  assign socket_a_attr_select_n = attr_n_reg[0];
  assign socket_a_output_enable_n = oe_n_reg[0];
  assign socket_a_write_enable_n = we_n_reg[0];
  assign socket_a_io_read_n = ior_n_reg[0];
  assign socket_a_io_write_n = iow_n_reg[0];
  assign socket_a_card_reset = ctrl_reg[0][CTRL_RESET];
  assign socket_a_power_ctl_0 = ctrl_reg[0][CTRL_PWR0];
  assign socket_a_power_ctl_1 = ctrl_reg[0][CTRL_PWR1];
  // socket b pins
  assign socket_b_card_address = card_addr_reg[1];
  assign socket_b_card_data_out = wdata_reg[1];
  assign socket_b_card_data_oe = data_oe_reg[1];
  assign socket_b_card_enable1_n = ce_reg[1][0];
  assign socket_b_card_enable2_n = ce_reg[1][1];
  assign socket_b_attr_select_n = attr_n_reg[1];
  assign socket_b_output_enable_n = oe_n_reg[1];
  assign socket_b_write_enable_n = we_n_reg[1];
  assign socket_b_io_read_n = ior_n_reg[1];
  assign socket_b_io_write_n = iow_n_reg[1];
  assign socket_b_card_reset = ctrl_reg[1][CTRL_RESET];
  assign socket_b_power_ctl_0 = ctrl_reg[1][CTRL_PWR0];
  assign socket_b_power_ctl_1 = ctrl_reg[1][CTRL_PWR1];
endmodule
`default_nettype wire

/* File: hw/card_socket_pkg.sv */
/*
  constants, register layout and cycle timing for the two-socket card signal block.
  assumes a 40 MHz pclk; offsets are byte addresses on the apb slave.
*/
`default_nettype none
package card_socket_pkg;
  // clock and cycle timing, in ns as specified, then cycles (least times round up)
  localparam int CLK_NS = 25;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 150;
  localparam int HOLD_NS = 30;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // card-side widths
  localparam int CARD_ADDR_W = 26;
  localparam int CARD_DATA_W = 16;
  // register offsets within one socket window; socket b sits one window higher
  localparam int SOCK_BIT = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_ADDR = 5'h08;
  localparam logic [4:0] OFF_WDATA = 5'h0c;
  localparam logic [4:0] OFF_CMD = 5'h10;
  localparam logic [4:0] OFF_RDATA = 5'h14;
  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_RESET = 0;
  localparam int CTRL_PWR0 = 1;
  localparam int CTRL_PWR1 = 2;
  localparam int CTRL_WIDE = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 4'h1;
  // command register fields
  localparam int CMD_W = 3;
  localparam int CMD_WRITE = 0;
  localparam int CMD_IO = 1;
  localparam int CMD_ATTR = 2;
  // status register fields
  localparam int ST_VS0 = 0;
  localparam int ST_VS1 = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_ERR = 3;
  // card cycle sequencer
  typedef enum {cyc_idle, cyc_setup, cyc_strobe, cyc_hold} cycle_state_e;
endpackage
`default_nettype wire

/* File: bench/card_model.sv */
/*
  behavioural card for one socket: one data word, wait stretch and 16-bit i/o flag.
  assumes active low strobes from the adapter, all sampled on the adapter clock.
*/
`default_nettype none
module card_model (
  input wire logic clk,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [15:0] dout,
  input wire logic [7:0] wait_len,
  input wire logic io16,
  output logic [15:0] din,
  output logic wait_n,
  output logic io16_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic stb;
  logic stb_q = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [15:0] mem = 16'h0000;
  logic [15:0] junk = 16'h5a5a;
  assign stb = !(oe_n & we_n & ior_n & iow_n);
  // stretch count loads as a strobe starts; write data is taken while the strobe is low
  always @(posedge clk) begin
    stb_q <= stb;
    junk <= ~junk;
    if (stb && !stb_q) begin
      cnt <= wait_len;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
    if (!we_n || !iow_n) begin
      mem <= dout;
    end
  end
  assign wait_n = (cnt == 8'h00);
  assign io16_n = !io16; // pulled up unless claimed
  // bus released outside reads: a changing pattern, so stale data never matches
  assign din = (!oe_n || !ior_n) ? mem : junk;
endmodule
`default_nettype wire

/* File: bench/card_socket_signals_assertions.sv */
/*
  concurrent checks on the card signal block, socket a in depth, socket b strobes.
  assumes one clock domain and the strobe timing in the package.
*/
`default_nettype none
module card_socket_checks
  import card_socket_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic socket_a_card_data_oe,
  input wire logic socket_a_card_enable1_n,
  input wire logic socket_a_card_enable2_n,
  input wire logic socket_a_attr_select_n,
  input wire logic socket_a_output_enable_n,
  input wire logic socket_a_write_enable_n,
  input wire logic socket_a_io_read_n,
  input wire logic socket_a_io_write_n,
  input wire logic socket_a_card_reset,
  input wire logic socket_a_power_ctl_0,
  input wire logic socket_a_power_ctl_1,
  input wire logic socket_a_wait_n,
  input wire logic socket_b_attr_select_n,
  input wire logic socket_b_io_read_n,
  input wire logic socket_b_io_write_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic stb;
  logic [31:0] wd_q;
  // any strobe of socket a low
  assign stb = !(socket_a_output_enable_n & socket_a_write_enable_n
    & socket_a_io_read_n & socket_a_io_write_n);
  always_ff @(posedge pclk) begin
    wd_q <= pwdata;
  end
  a_io_attr_a: assert property (!(socket_a_io_read_n && socket_a_io_write_n)
    |-> !socket_a_attr_select_n) else $error("socket a i/o strobe in common mode");
  a_io_attr_b: assert property (!(socket_b_io_read_n && socket_b_io_write_n)
    |-> !socket_b_attr_select_n) else $error("socket b i/o strobe in common mode");
  a_strobe_min: assert property ($rose(stb) |-> stb [*6])
    else $error("strobe shorter than six cycles");
  a_strobe_bound: assert property ($rose(stb) |-> ##[6:80] !stb)
    else $error("strobe never ends");
  a_wait_holds: assert property ((stb && !socket_a_wait_n) [*5] |=> stb)
    else $error("strobe ended while wait low");
  a_enable_in_strobe: assert property (stb
    |-> !(socket_a_card_enable1_n && socket_a_card_enable2_n)) else $error("no enable");
  a_read_no_drive: assert property (!(socket_a_output_enable_n && socket_a_io_read_n)
    |-> !socket_a_card_data_oe) else $error("adapter drives data during read");
  a_write_drives: assert property (!socket_a_write_enable_n
    |-> socket_a_card_data_oe) else $error("adapter not driving data on write");
  a_reset_ctl: assert property (psel && penable && pwrite && paddr == ADDR_W'(OFF_CTRL)
    |=> {socket_a_power_ctl_1, socket_a_power_ctl_0, socket_a_card_reset} == wd_q[2:0])
    else $error("reset or power pins differ from control write");
  c_io_read: cover property ($rose(stb) && !socket_a_io_read_n);
  c_io_write: cover property ($rose(stb) && !socket_a_io_write_n);
  c_wait: cover property (stb && !socket_a_wait_n);
endmodule
bind card_socket_signals card_socket_checks #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* File: bench/testbench.sv */
/*
  self-checking bench: apb master, two card models, one task per scenario.
  assumes the block answers every apb access without wait states or with few.
*/
`default_nettype none
module testbench
  import card_socket_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [25:0] socket_a_card_address, socket_b_card_address, seen_addr;
  logic [15:0] socket_a_card_data_in, socket_a_card_data_out;
  logic [15:0] socket_b_card_data_in, socket_b_card_data_out;
  logic socket_a_card_data_oe, socket_a_card_enable1_n, socket_a_card_enable2_n;
  logic socket_a_attr_select_n, socket_a_output_enable_n, socket_a_write_enable_n;
  logic socket_a_io_read_n, socket_a_io_write_n, socket_a_card_reset;
  logic socket_a_power_ctl_0, socket_a_power_ctl_1, socket_a_wait_n, socket_a_io16_n;
  logic socket_b_card_data_oe, socket_b_card_enable1_n, socket_b_card_enable2_n;
  logic socket_b_attr_select_n, socket_b_output_enable_n, socket_b_write_enable_n;
  logic socket_b_io_read_n, socket_b_io_write_n, socket_b_card_reset;
  logic socket_b_power_ctl_0, socket_b_power_ctl_1, socket_b_wait_n, socket_b_io16_n;
  logic socket_a_volt_sense_0 = 1'b1, socket_a_volt_sense_1 = 1'b1;
  logic socket_b_volt_sense_0 = 1'b1, socket_b_volt_sense_1 = 1'b1;
  logic [7:0] wl_a = 8'h00, wl_b = 8'h00;
  logic io16_a = 1'b0, io16_b = 1'b0, stb_q = 1'b0;
  logic [6:0] seen = 7'h00;
  int len = 0, nstb = 0, checks = 0, n_errors = 0;
  wire stb_a = !(socket_a_output_enable_n & socket_a_write_enable_n
    & socket_a_io_read_n & socket_a_io_write_n);
  card_socket_signals u_dut (.*);
  card_model u_card_a (.clk(pclk), .oe_n(socket_a_output_enable_n),
    .we_n(socket_a_write_enable_n), .ior_n(socket_a_io_read_n), .iow_n(socket_a_io_write_n),
    .dout(socket_a_card_data_out), .wait_len(wl_a), .io16(io16_a),
    .din(socket_a_card_data_in), .wait_n(socket_a_wait_n), .io16_n(socket_a_io16_n));
  card_model u_card_b (.clk(pclk), .oe_n(socket_b_output_enable_n),
    .we_n(socket_b_write_enable_n), .ior_n(socket_b_io_read_n), .iow_n(socket_b_io_write_n),
    .dout(socket_b_card_data_out), .wait_len(wl_b), .io16(io16_b),
    .din(socket_b_card_data_in), .wait_n(socket_b_wait_n), .io16_n(socket_b_io16_n));
  always #12.5 pclk = ~pclk;
  // snapshot of socket a pins and strobe length while a strobe is low
  always @(posedge pclk) begin
    stb_q <= stb_a;
    if (stb_a) begin
      seen <= {socket_a_attr_select_n, socket_a_card_enable2_n, socket_a_card_enable1_n,
        socket_a_output_enable_n, socket_a_write_enable_n, socket_a_io_read_n,
        socket_a_io_write_n};
      seen_addr <= socket_a_card_address;
      len <= stb_q ? len + 1 : 1;
      nstb <= stb_q ? nstb : nstb + 1;
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      test_done();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // start a card cycle on one socket (a unless told) and poll busy with a bound
  task automatic op(input logic [25:0] ad, input logic [2:0] c, input logic [2:0] sk = 3'h0);
    int n;
    apb(1'b1, {sk, OFF_ADDR}, 32'(ad));
    apb(1'b1, {sk, OFF_CMD}, 32'(c));
    n = 0;
    do begin
      apb(1'b0, {sk, OFF_STATUS}, 32'h0);
      n++;
    end while (r[ST_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic t_regs();
    apb(1'b0, {3'h0, OFF_CTRL}, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h6);
    chk(32'({socket_a_power_ctl_1, socket_a_power_ctl_0, socket_a_card_reset}), 32'h6);
    chk(32'({socket_b_power_ctl_1, socket_b_power_ctl_0, socket_b_card_reset}), 32'h1);
    apb(1'b1, {3'h1, OFF_CTRL}, 32'h2);
    chk(32'({socket_b_power_ctl_1, socket_b_power_ctl_0, socket_b_card_reset}), 32'h2);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_sense();
    socket_a_volt_sense_1 <= 1'b0;
    socket_b_volt_sense_0 <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, {3'h0, OFF_STATUS}, 32'h0);
    chk(r & 32'h3, 32'h1);
    apb(1'b0, {3'h1, OFF_STATUS}, 32'h0);
    chk(r & 32'h3, 32'h2);
    $display("t_sense done");
  endtask
  task automatic t_mem();
    apb(1'b1, {3'h0, OFF_CTRL}, 32'h8);
    apb(1'b1, {3'h0, OFF_WDATA}, 32'ha55a);
    op(26'h3fffffe, 3'h1);
    chk(32'(seen), 32'h4b);
    chk(32'(seen_addr), 32'h3fffffe);
    chk(32'(len), 32'h6);
    op(26'h0000001, 3'h1);
    chk(32'(seen), 32'h5b);
    $display("t_mem done");
  endtask
  task automatic t_wait();
    wl_a <= 8'h0c;
    op(26'h0, 3'h0);
    chk(32'(seen), 32'h47);
    chk(32'(len > 13), 32'h1);
    apb(1'b0, {3'h0, OFF_RDATA}, 32'h0);
    chk(r, 32'ha55a);
    wl_a <= 8'h00;
    $display("t_wait done");
  endtask
  task automatic t_io();
    op(26'h0, 3'h6);
    chk(32'(seen), 32'h2d);
    io16_a <= 1'b1;
    op(26'h1, 3'h7);
    chk(32'(seen), 32'h1e);
    $display("t_io done");
  endtask
  // socket b on its own: i/o write then i/o read back through its card
  task automatic t_sock_b();
    apb(1'b1, {3'h1, OFF_WDATA}, 32'h1234);
    op(26'h2, 3'h7, 3'h1);
    chk(32'(socket_b_card_address), 32'h2);
    op(26'h2, 3'h6, 3'h1);
    apb(1'b0, {3'h1, OFF_RDATA}, 32'h0);
    chk(r, 32'h1234);
    $display("t_sock_b done");
  endtask
  task automatic t_refuse();
    int n0;
    n0 = nstb;
    op(26'h0, 3'h2);
    chk(32'(nstb), 32'(n0));
    chk(r & 32'h8, 32'h8);
    apb(1'b1, {3'h0, OFF_STATUS}, 32'h8);
    apb(1'b0, {3'h0, OFF_STATUS}, 32'h0);
    chk(r & 32'h8, 32'h0);
    $display("t_refuse done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_sense();
    t_mem();
    t_wait();
    t_io();
    t_sock_b();
    t_refuse();
    test_done();
  end
endmodule
`default_nettype wire
